// file: core/tcc_pkg.sv
package tcc_pkg;

   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_CTRL = 8'h00;  // mode, preload, fast, direction, count enable
   localparam logic [7:0] OFS_CHEN = 8'h04;  // channel output enable
   localparam logic [7:0] OFS_LOCK = 8'h08;  // protection level
   localparam logic [7:0] OFS_TRIG = 8'h0C;  // trigger source select
   localparam logic [7:0] OFS_CMP  = 8'h10;  // compare value (preload copy)
   localparam logic [7:0] OFS_ACT  = 8'h14;  // active compare value, read only
   localparam logic [7:0] OFS_PER  = 8'h18;  // counter period
   localparam logic [7:0] OFS_STAT = 8'h1C;  // live state, read only

   // direction select codes
   localparam logic [1:0] DIR_OUT = 2'h0;
   localparam logic [1:0] DIR_TI1 = 2'h1;
   localparam logic [1:0] DIR_TI2 = 2'h2;
   localparam logic [1:0] DIR_TRC = 2'h3;

   // compare mode codes
   localparam logic [2:0] MODE_FROZEN = 3'h0;
   localparam logic [2:0] MODE_SET    = 3'h1;
   localparam logic [2:0] MODE_CLR    = 3'h2;
   localparam logic [2:0] MODE_TOGGLE = 3'h3;
   localparam logic [2:0] MODE_LOW    = 3'h4;
   localparam logic [2:0] MODE_HIGH   = 3'h5;
   localparam logic [2:0] MODE_PWM_MODE_ONE   = 3'h6;
   localparam logic [2:0] MODE_PWM_MODE_TWO   = 3'h7;

   localparam logic [1:0] LOCK_TOP   = 2'h3;  // highest protection level
   localparam logic [2:0] TS_INT_MAX = 3'h3;  // codes 0..3 pick an internal trigger

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // trigger-to-output latencies in clock cycles
   localparam int FAST_LAT_CYC = 3;
   localparam int SLOW_LAT_CYC = 5;
   localparam int FAST_IDX     = FAST_LAT_CYC - 2;  // pipe stage feeding the output flop
   localparam int SLOW_IDX     = SLOW_LAT_CYC - 3;  // pipe stage resetting the counter

   typedef struct packed {
      logic       cntEn;
      logic [2:0] compareMode1;
      logic       comparePreloadEnable;
      logic       compareFastEnable;
      logic [1:0] channelDirectionSelect;
   } tcc_ctrl_type;

   localparam tcc_ctrl_type CTRL_RST = '0;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } tcc_wreq_type;

endpackage

// file: core/tcc_channel1_ctrl.sv
// How it works
// - with preload on, software compare accesses touch only the preload copy
// - with preload on, each update event copies preload into active compare
// - with preload off, compare writes reach the active value at once
// - preload bit frozen while protection level is 3 and channel is output
// - fast off: output follows counter compare, trigger acts after five cycles
// - fast on: trigger edge acts as a match, forcing the compare level
// - fast path: trigger sample flop to output takes three cycles
// - fast enable acts only in the two pwm modes
// - mode 110 is pwm one, mode 111 is pwm two
// - direction 00 output, 01 input from timer input 1, 10 from input 2
// - direction 11 takes internal trigger capture, only with internal trigger source
// - direction field writable only while channel output enable is 0
`timescale 1ns/1ps
module tcc_channel1_ctrl
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timer side
   input  wire logic        trigIn,
   input  wire logic        timerInput1,
   input  wire logic        timerInput2,
   input  wire logic        internalTriggerCapture,
   output logic             channelOut,
   output logic             captureInput1,
   output logic             updateEvent
);

   // bus state
   logic         awHeld_r, awHeld_nxt;
   logic         wHeld_r, wHeld_nxt;
   logic [7:0]   awAddr_r, awAddr_nxt;
   logic [31:0]  wData_r, wData_nxt;
   logic [3:0]   wStrb_r, wStrb_nxt;
   logic         bValid_r, bValid_nxt;
   logic [1:0]   bResp_r, bResp_nxt;
   logic         rValid_r, rValid_nxt;
   logic [1:0]   rResp_r, rResp_nxt;
   logic [31:0]  rData_r, rData_nxt;
   tcc_wreq_type wReq;
   logic         doWrite;
   logic         doRead;

   // configuration state
   tcc_ctrl_type ctrl_r, ctrl_nxt;
   logic         outEnable_r, outEnable_nxt;
   logic [1:0]   lockLevel_r, lockLevel_nxt;
   logic [2:0]   trigSel_r, trigSel_nxt;
   logic [CNT_W-1:0] preload_r, preload_nxt;
   logic [CNT_W-1:0] active_r, active_nxt;
   logic [CNT_W-1:0] period_r, period_nxt;

   // timing state
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic         trigSmp_r, trigSmp_nxt;
   logic         trigDly_r, trigDly_nxt;
   logic [SLOW_IDX:0] edgePipe_r, edgePipe_nxt;
   logic         forceHold_r, forceHold_nxt;
   logic         ref_r, ref_nxt;
   logic         chanOut_r, chanOut_nxt;
   logic         capIn_r, capIn_nxt;
   logic         update_r, update_nxt;

   logic         tsInternal;
   logic         isPwm;
   logic         fastActive;
   logic         cntLtCmp;
   logic         cntMatch;
   logic         updNow;

   function automatic logic [31:0] mergeBytes(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = newVal[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign tsInternal = (trigSel_r <= TS_INT_MAX);
   assign isPwm      = (ctrl_r.compareMode1 == MODE_PWM_MODE_ONE)
                    || (ctrl_r.compareMode1 == MODE_PWM_MODE_TWO);
   assign fastActive = ctrl_r.compareFastEnable && isPwm;
   assign cntLtCmp   = (cnt_r < active_r);
   assign cntMatch   = (cnt_r == active_r);

   // handshakes are combinational off held state; one write and one read in flight
   assign s_axi_awready = !awHeld_r && !bValid_r;
   assign s_axi_wready  = !wHeld_r && !bValid_r;
   assign s_axi_arready = !rValid_r;
   assign s_axi_bvalid  = bValid_r;
   assign s_axi_bresp   = bResp_r;
   assign s_axi_rvalid  = rValid_r;
   assign s_axi_rresp   = rResp_r;
   assign s_axi_rdata   = rData_r;
   assign channelOut    = chanOut_r;
   assign captureInput1 = capIn_r;
   assign updateEvent   = update_r;

   assign wReq    = '{addr: awAddr_r, data: wData_r, strb: wStrb_r};
   assign doWrite = awHeld_r && wHeld_r && !bValid_r;
   assign doRead  = s_axi_arvalid && s_axi_arready;

   // bus channel next state: address and data may arrive in either order
   always_comb
   begin
      awHeld_nxt = awHeld_r;
      wHeld_nxt  = wHeld_r;
      awAddr_nxt = awAddr_r;
      wData_nxt  = wData_r;
      wStrb_nxt  = wStrb_r;
      bValid_nxt = bValid_r;
      bResp_nxt  = bResp_r;
      rValid_nxt = rValid_r;
      rResp_nxt  = rResp_r;
      rData_nxt  = rData_r;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wHeld_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      if (doWrite)
      begin
         awHeld_nxt = 1'b0;
         wHeld_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         unique case (wReq.addr)
            OFS_CTRL, OFS_CHEN, OFS_LOCK, OFS_TRIG, OFS_CMP, OFS_PER: bResp_nxt = RESP_OKAY;
            default: bResp_nxt = RESP_SLVERR;  // read-only and unmapped words
         endcase
      end
      else if (bValid_r && s_axi_bready)
      begin
         bValid_nxt = 1'b0;
      end
      if (doRead)
      begin
         rValid_nxt = 1'b1;
         rResp_nxt  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CTRL: rData_nxt = 32'(ctrl_r);
            OFS_CHEN: rData_nxt = 32'(outEnable_r);
            OFS_LOCK: rData_nxt = 32'(lockLevel_r);
            OFS_TRIG: rData_nxt = 32'(trigSel_r);
            OFS_CMP:  rData_nxt = 32'(preload_r);
            OFS_ACT:  rData_nxt = 32'(active_r);
            OFS_PER:  rData_nxt = 32'(period_r);
            OFS_STAT: rData_nxt = {16'(cnt_r), 12'h000, tsInternal, capIn_r, ref_r, chanOut_r};
            default:
            begin
               rData_nxt = 32'h0000_0000;
               rResp_nxt = RESP_SLVERR;
            end
         endcase
      end
      else if (rValid_r && s_axi_rready)
      begin
         rValid_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
         bValid_r <= 1'b0;
         bResp_r  <= RESP_OKAY;
         rValid_r <= 1'b0;
         rResp_r  <= RESP_OKAY;
         rData_r  <= 32'h0000_0000;
      end
      else
      begin
         awHeld_r <= awHeld_nxt;
         wHeld_r  <= wHeld_nxt;
         awAddr_r <= awAddr_nxt;
         wData_r  <= wData_nxt;
         wStrb_r  <= wStrb_nxt;
         bValid_r <= bValid_nxt;
         bResp_r  <= bResp_nxt;
         rValid_r <= rValid_nxt;
         rResp_r  <= rResp_nxt;
         rData_r  <= rData_nxt;
      end
   end

   // configuration next state; guarded fields keep their value on a blocked write
   always_comb
   begin
      tcc_ctrl_type newCtrl;
      logic [31:0]  ctrlWord;
      logic [31:0]  cmpWord;
      newCtrl       = ctrl_r;
      ctrlWord      = mergeBytes(32'(ctrl_r), wReq.data, wReq.strb);
      cmpWord       = mergeBytes(32'(preload_r), wReq.data, wReq.strb);
      ctrl_nxt      = ctrl_r;
      outEnable_nxt = outEnable_r;
      lockLevel_nxt = lockLevel_r;
      trigSel_nxt   = trigSel_r;
      preload_nxt   = preload_r;
      active_nxt    = active_r;
      period_nxt    = period_r;
      // update first so a same-cycle write lands in preload, not lost
      if (updNow && ctrl_r.comparePreloadEnable)
      begin
         active_nxt = preload_r;
      end
      if (doWrite)
      begin
         unique case (wReq.addr)
            OFS_CTRL:
            begin
               newCtrl = tcc_ctrl_type'(ctrlWord[7:0]);
               if (outEnable_r)
               begin
                  newCtrl.channelDirectionSelect = ctrl_r.channelDirectionSelect;
               end
               if (lockLevel_r == LOCK_TOP && ctrl_r.channelDirectionSelect == DIR_OUT)
               begin
                  newCtrl.comparePreloadEnable = ctrl_r.comparePreloadEnable;
               end
               ctrl_nxt = newCtrl;
            end
            OFS_CHEN: outEnable_nxt = wReq.strb[0] ? wReq.data[0] : outEnable_r;
            OFS_LOCK: lockLevel_nxt = wReq.strb[0] ? wReq.data[1:0] : lockLevel_r;
            OFS_TRIG: trigSel_nxt = wReq.strb[0] ? wReq.data[2:0] : trigSel_r;
            OFS_CMP:
            begin
               preload_nxt = cmpWord[CNT_W-1:0];
               if (!ctrl_r.comparePreloadEnable)
               begin
                  active_nxt = cmpWord[CNT_W-1:0];
               end
            end
            OFS_PER: period_nxt = CNT_W'(mergeBytes(32'(period_r), wReq.data, wReq.strb));
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ctrl_r      <= CTRL_RST;
         outEnable_r <= 1'b0;
         lockLevel_r <= 2'h0;
         trigSel_r   <= 3'h0;
         preload_r   <= '0;
         active_r    <= '0;
         period_r    <= '1;
      end
      else
      begin
         ctrl_r      <= ctrl_nxt;
         outEnable_r <= outEnable_nxt;
         lockLevel_r <= lockLevel_nxt;
         trigSel_r   <= trigSel_nxt;
         preload_r   <= preload_nxt;
         active_r    <= active_nxt;
         period_r    <= period_nxt;
      end
   end

   // counter, trigger pipe and channel output next state
   always_comb
   begin
      trigSmp_nxt  = trigIn;                   // trigger sampling flop
      trigDly_nxt  = trigSmp_r;
      edgePipe_nxt = {edgePipe_r[SLOW_IDX-1:0], trigSmp_r & ~trigDly_r};
      updNow       = 1'b0;
      cnt_nxt      = cnt_r;
      // trigger reset reaches the counter late, so the compare path needs five cycles
      if (edgePipe_r[SLOW_IDX])
      begin
         cnt_nxt = '0;
         updNow  = 1'b1;
      end
      else if (ctrl_r.cntEn)
      begin
         if (cnt_r == period_r)
         begin
            cnt_nxt = '0;
            updNow  = 1'b1;
         end
         else
         begin
            cnt_nxt = cnt_r + CNT_W'(1);
         end
      end
      update_nxt = updNow;
      ref_nxt    = ref_r;
      unique case (ctrl_r.compareMode1)
         MODE_FROZEN: ref_nxt = ref_r;
         MODE_SET:    ref_nxt = cntMatch ? 1'b1 : ref_r;
         MODE_CLR:    ref_nxt = cntMatch ? 1'b0 : ref_r;
         MODE_TOGGLE: ref_nxt = cntMatch ? ~ref_r : ref_r;
         MODE_LOW:    ref_nxt = 1'b0;
         MODE_HIGH:   ref_nxt = 1'b1;
         MODE_PWM_MODE_ONE:   ref_nxt = cntLtCmp;
         MODE_PWM_MODE_TWO:   ref_nxt = ~cntLtCmp;
      endcase
      // fast path holds the match level until the counter reset takes over
      forceHold_nxt = fastActive
                    && (edgePipe_r[FAST_IDX] || (forceHold_r && !edgePipe_r[SLOW_IDX]));
      if (fastActive && (edgePipe_r[FAST_IDX] || forceHold_r))
      begin
         ref_nxt = (ctrl_r.compareMode1 == MODE_PWM_MODE_TWO);
      end
      chanOut_nxt = ref_nxt && outEnable_r
                 && (ctrl_r.channelDirectionSelect == DIR_OUT);
      unique case (ctrl_r.channelDirectionSelect)
         DIR_OUT: capIn_nxt = 1'b0;
         DIR_TI1: capIn_nxt = timerInput1;
         DIR_TI2: capIn_nxt = timerInput2;
         DIR_TRC: capIn_nxt = tsInternal && internalTriggerCapture;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cnt_r       <= '0;
         trigSmp_r   <= 1'b0;
         trigDly_r   <= 1'b0;
         edgePipe_r  <= '0;
         forceHold_r <= 1'b0;
         ref_r       <= 1'b0;
         chanOut_r   <= 1'b0;
         capIn_r     <= 1'b0;
         update_r    <= 1'b0;
      end
      else
      begin
         cnt_r       <= cnt_nxt;
         trigSmp_r   <= trigSmp_nxt;
         trigDly_r   <= trigDly_nxt;
         edgePipe_r  <= edgePipe_nxt;
         forceHold_r <= forceHold_nxt;
         ref_r       <= ref_nxt;
         chanOut_r   <= chanOut_nxt;
         capIn_r     <= capIn_nxt;
         update_r    <= update_nxt;
      end
   end

endmodule

// file: testbench/tcc_channel1_ctrl_asserts.sv
`timescale 1ns/1ps
module tcc_channel1_ctrl_asserts
   import tcc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        trigIn,
   input wire logic        channelOut,
   input wire logic        captureInput1,
   input wire logic        updateEvent
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // a response must not vanish or change before the master takes it
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // both halves taken at one edge: the write lands at the next edge, the answer shows after it
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write answer late");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   bresp_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   // reset must be seen even while the default disable is active
   reset_clear_a: assert property (disable iff (1'b0) rst |=> !channelOut
      && !captureInput1 && !updateEvent && !s_axi_bvalid)
      else $error("outputs not cleared by reset");
   trig_update_a: assert property ($rose(trigIn) |-> ##[3:5] updateEvent)
      else $error("trigger gave no update event");

   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (updateEvent);
   cover property ($rose(channelOut));
endmodule

bind tcc_channel1_ctrl tcc_channel1_ctrl_asserts u_asserts (.*);

// file: testbench/tcc_channel1_ctrl_tb_top.sv
`timescale 1ns/1ps
module tcc_channel1_ctrl_tb_top;
   import tcc_pkg::*;
   logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic        bvalid, arready, rvalid, trigIn, ti1, ti2, itc, chOut, capIn, updEv;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   int          err_total, samples_checked, lat;
   int          tab [4][3] = '{'{6, 1, 3}, '{7, 1, 3}, '{6, 0, 0}, '{5, 1, 0}};

   tcc_channel1_ctrl #(.CNT_W(8)) u_dut (.mclk(mclk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .trigIn(trigIn), .timerInput1(ti1), .timerInput2(ti2), .internalTriggerCapture(itc),
      .channelOut(chOut), .captureInput1(capIn), .updateEvent(updEv));

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic test_done;
      $display("compares %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   // ready, valid and answers are sampled at the falling edge, changes go out by nba on the
   // rising edge; bready and rready rise only once the answer is seen, so answers must wait
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb, sb;
      int   n;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      tb = 1'b0;
      n  = 0;
      while (!tb && n < 40)
      begin
         @(negedge mclk);
         if (!ta && awready === 1'b1) ta = 1'b1;
         if (!tw && wready === 1'b1) tw = 1'b1;
         sb   = (bvalid === 1'b1);
         tb   = sb && (bready === 1'b1);
         resp = bresp;
         @(posedge mclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         bready <= sb && !tb;
         n++;
      end
      if (!tb)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: write answer timed out", $time);
         test_done();
      end
   endtask

   task automatic axr(input logic [7:0] a);
      logic ta, tr, sr;
      int   n;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      ta = 1'b0;
      tr = 1'b0;
      n  = 0;
      while (!tr && n < 40)
      begin
         @(negedge mclk);
         if (!ta && arready === 1'b1) ta = 1'b1;
         sr   = (rvalid === 1'b1);
         tr   = sr && (rready === 1'b1);
         rd   = rdata;
         resp = rresp;
         @(posedge mclk);
         if (ta) arvalid <= 1'b0;
         rready <= sr && !tr;
         n++;
      end
      if (!tr)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: read answer timed out", $time);
         test_done();
      end
   endtask

   // one rising trigger edge; l is the first cycle after sampling at which the output moved,
   // and the update pulse must show once the trigger has reset the counter
   task automatic trig(output int l);
      logic b;
      int   u;
      l = 0;
      u = 0;
      @(negedge mclk);
      b = chOut;  // settled value, away from the launching edge
      @(posedge mclk);
      trigIn <= 1'b1;
      @(posedge mclk);
      for (int k = 0; k < 9; k++)
      begin
         @(negedge mclk);
         if (chOut !== b && l == 0) l = k;
         if (updEv === 1'b1 && u == 0) u = k;
      end
      chk(u, 4);
      @(posedge mclk);
      trigIn <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic capchk(input logic [1:0] dir, input logic [2:0] ts);
      axw(OFS_TRIG, {29'h0, ts});
      axw(OFS_CTRL, {30'h0, dir});
      for (int v = 0; v < 2; v++)
      begin
         @(posedge mclk);
         ti1 <= v[0];
         ti2 <= !v[0];
         itc <= v[0];
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         chk(capIn, (dir == DIR_TI1 || (dir == DIR_TRC && ts <= TS_INT_MAX)) ? v[0] :
             (dir == DIR_TI2) ? !v[0] : 1'b0);
      end
   endtask

   initial
   begin
      rst             = 1'b1;
      awvalid         = 1'b0;
      wvalid          = 1'b0;
      bready          = 1'b0;
      arvalid         = 1'b0;
      rready          = 1'b0;
      awaddr          = '0;
      araddr          = '0;
      wdata           = '0;
      trigIn          = 1'b0;
      ti1             = 1'b0;
      ti2             = 1'b0;
      itc             = 1'b0;
      err_total       = 0;
      samples_checked = 0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      axr(OFS_CTRL);
      chk(rd, 32'h0000_0000);
      axr(8'h20);
      chk(resp, RESP_SLVERR);
      axw(OFS_ACT, 32'h0000_0011);
      chk(resp, RESP_SLVERR);
      $display("test reset done");
      axw(OFS_CMP, 32'h0000_0020);
      axr(OFS_ACT);
      chk(rd, 32'h0000_0020);
      axw(OFS_CTRL, 32'h0000_0008);
      axw(OFS_CMP, 32'h0000_0040);
      axr(OFS_ACT);
      chk(rd, 32'h0000_0020);
      axr(OFS_CMP);
      chk(rd, 32'h0000_0040);
      trig(lat);
      axr(OFS_ACT);
      chk(rd, 32'h0000_0040);
      $display("test preload done");
      for (int d = 1; d < 4; d++)
         capchk(d[1:0], 3'h0);
      capchk(DIR_TRC, 3'h4);
      capchk(DIR_OUT, 3'h0);
      $display("test direction done");
      axw(OFS_CHEN, 32'h0000_0001);
      axw(OFS_CTRL, 32'h0000_0001);
      axr(OFS_CTRL);
      chk(rd[1:0], DIR_OUT);
      $display("test direction lock done");
      axw(OFS_CMP, 32'h0000_00FF);
      foreach (tab[i])
      begin
         // preload stays on in every pwm setup, as software is told to do
         axw(OFS_CTRL, {25'h0, tab[i][0][2:0], 1'b1, tab[i][1][0], 2'h0});
         repeat (4) @(posedge mclk);
         trig(lat);
         chk(lat, tab[i][2]);
      end
      // slow path: the trigger's update loads compare zero, so pwm one falls five cycles on
      axw(OFS_CMP, 32'h0000_0000);
      axw(OFS_CTRL, 32'h0000_0068);
      repeat (4) @(posedge mclk);
      trig(lat);
      chk(lat, SLOW_LAT_CYC);
      $display("test fast done");
      axw(OFS_CHEN, 32'h0000_0000);
      axw(OFS_CTRL, 32'h0000_0008);
      axw(OFS_LOCK, 32'h0000_0003);
      axw(OFS_CTRL, 32'h0000_0000);
      axr(OFS_CTRL);
      chk(rd, 32'h0000_0008);
      axw(OFS_CTRL, 32'h0000_0009);
      axw(OFS_CTRL, 32'h0000_0001);
      axr(OFS_CTRL);
      chk(rd, 32'h0000_0001);
      $display("test protection done");
      test_done();
   end
endmodule
